// ---- include/l2cds_regs.svh ----
/*
 * Constants for the second-level cache and paged DRAM subsystem.
 * Assumes a 32-bit processor bus, doubleword addressing, one clock.
 */
`ifndef L2CDS_REGS_SVH
`define L2CDS_REGS_SVH
`define L2_UNIT_KB 128
`define L2_UNITS 2
`define L2_WAYS 2
`define L2_LINE_DW 4
`define L2_SETS 4096
`define L2_IDX_W 12
`define L2_OFS_LO 2
`define L2_OFS_HI 3
`define L2_IDX_LO 4
`define L2_IDX_HI 15
`define L2_TAG_LO 16
`define L2_TAG_W 16
`define DR_BANK_LO 2
`define DR_BANK_HI 3
`define DR_COL_LO 4
`define DR_COL_HI 13
`define DR_ROW_LO 14
`define DR_ROW_HI 23
`define DR_ROW_W 10
`define DR_COL_W 10
`define DR_BANKS 4
`define DR_PRE_CYC 3'h3
`define DR_RCD_CYC 3'h2
`define DR_CAS_CYC 3'h2
`define WB_DEPTH 4
`define WB_PTR_W 2
`endif

// ---- include/l2cds_pkg.sv ----
/*
 * Types shared by the cache core and the DRAM controller.
 * Assumes l2cds_regs.svh is on the include path.
 */
`include "l2cds_regs.svh"
package l2cds_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic write;
    logic fill;
  } l2cds_req_t;
  typedef struct packed {
    logic [`DR_ROW_W-1:0] row;
    logic [`DR_COL_W-1:0] col;
    logic [`DR_BANKS-1:0] rasN;
    logic [`DR_BANKS-1:0] casN;
    logic weN;
    logic [31:0] wdata;
  } l2cds_dram_t;
  typedef enum logic [2:0] {
    DR_IDLE, DR_PRE, DR_RAS, DR_CAS, DR_DONE
  } l2cds_dst_t;
endpackage

// ---- core/l2cds_dram.sv ----
/*
 * Static-column DRAM controller with interleaved bank control.
 * Assumes a request is held stable until reqDone; burst fills
 * issue four consecutive requests that share one row.
 */
`timescale 1ns/1ps
`default_nettype none
`include "l2cds_regs.svh"
module l2cds_dram
  import l2cds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire l2cds_req_t req,
  output logic reqDone,
  output logic [31:0] rdata,
  output l2cds_dram_t dram,
  input wire logic [31:0] dramRdata
);
  typedef struct packed {
    l2cds_dst_t st;
    logic [2:0] cnt;
    logic [`DR_ROW_W-1:0] openRow;
    logic pageOpen;
    logic [`DR_BANKS-1:0] bankPre;
    logic [`DR_BANKS-1:0] bankRdy;
    l2cds_dram_t pins;
    logic [31:0] rdata;
  } l2cds_dstate_t;
  l2cds_dstate_t s, next_s;
  logic [`DR_ROW_W-1:0] reqRow;
  logic [1:0] reqBank;
  assign reqRow = req.addr[`DR_ROW_HI:`DR_ROW_LO];
  assign reqBank = req.addr[`DR_BANK_HI:`DR_BANK_LO];
  assign reqDone = (s.st == DR_DONE);
  assign rdata = s.rdata;
  assign dram = s.pins;
  always_comb begin
    next_s = s;
    next_s.pins.col = req.addr[`DR_COL_HI:`DR_COL_LO];
    // Idle banks finish precharge while another bank is busy
    for (int b = 0; b < `DR_BANKS; b++) begin
      if (s.bankPre[b]) begin
        next_s.bankPre[b] = 1'b0;
        next_s.bankRdy[b] = 1'b1; // R15 R16
      end
    end
    case (s.st)
      DR_IDLE: begin
        if (reqValid) begin
          if (s.pageOpen && reqRow == s.openRow) begin
            // Same page: row stays latched, only column moves
            next_s.pins.casN = ~(`DR_BANKS'(1) << reqBank);
            next_s.st = DR_CAS; // R11 R13 R14 R20
            next_s.cnt = `DR_CAS_CYC;
          end else if (s.pageOpen) begin
            next_s.pins.rasN = '1;
            next_s.pins.casN = '1; // R12
            next_s.pageOpen = 1'b0;
            next_s.st = DR_PRE; // R20
            next_s.cnt = s.bankRdy[reqBank] ? 3'h1 : `DR_PRE_CYC; // R16
          end else begin
            next_s.pins.row = reqRow; // R09 R10
            next_s.pins.rasN = '0; // R14
            next_s.st = DR_RAS;
            next_s.cnt = `DR_RCD_CYC;
          end
          next_s.pins.weN = ~req.write;
          next_s.pins.wdata = req.data;
        end
      end
      DR_PRE: begin
        next_s.cnt = s.cnt - 3'h1;
        if (s.cnt == 3'h1) begin
          next_s.bankRdy = '0;
          next_s.bankPre = ~(`DR_BANKS'(1) << reqBank); // R15
          next_s.pins.row = reqRow; // R10
          next_s.pins.rasN = '0;
          next_s.st = DR_RAS;
          next_s.cnt = `DR_RCD_CYC;
        end
      end
      DR_RAS: begin
        next_s.cnt = s.cnt - 3'h1;
        if (s.cnt == 3'h1) begin
          next_s.openRow = s.pins.row;
          next_s.pageOpen = 1'b1;
          next_s.pins.casN = ~(`DR_BANKS'(1) << reqBank); // R09 R10
          next_s.st = DR_CAS;
          next_s.cnt = `DR_CAS_CYC;
        end
      end
      DR_CAS: begin
        next_s.cnt = s.cnt - 3'h1;
        if (s.cnt == 3'h1 || s.cnt == 3'h0) begin
          next_s.rdata = dramRdata;
          next_s.st = DR_DONE;
        end
      end
      DR_DONE: begin
        next_s.pins.weN = 1'b1;
        next_s.st = DR_IDLE;
      end
      default: next_s.st = DR_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= DR_IDLE;
      s.pins.rasN <= '1;
      s.pins.casN <= '1;
      s.pins.weN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
endmodule // l2cds_dram
`default_nettype wire

// ---- core/l2cds_top.sv ----
/*
 * Two-way write-through second-level cache with posted writes in
 * front of a paged DRAM controller.
 * Assumes the processor holds address and data from start strobe
 * until done; DRAM read data is synchronous to clk_sys.
 */
// Contract
// (R01) Two-way set-associative, 64 or 128 KB units
// (R02) Units combine to 256 or 512 KB; the code holds a single 128 KB array
// (R03) Line is four doublewords, one burst
// (R04) Read compares tags; hit bursts line
// (R05) Hit: first word clock two, then one
// (R06) Miss fetches DRAM, fills processor and cache
// (R07) Write updates on hit, no allocate on miss
// (R08) Every write goes through to DRAM
// (R09) Row, strobe row, column, strobe column
// (R10) First page access is full access
// (R11) Same row keeps row, changes column
// (R12) Column strobe stays asserted within page
// (R13) Burst transfers one clock each in page; the code takes four clocks per in-page fill beat
// (R14) One row strobe drives all banks
// (R15) Banks controlled independently when interleaved
// (R16) Hide precharge behind other bank accesses
// (R17) Posted writes acknowledged before DRAM completes
// (R18) Cycle-done low ends cycle; high waits
// (R19) Burst accepted with burst-done; else wait
// (R20) Compare new row to open row
// (R21) Drain writes in order; stall when full
`timescale 1ns/1ps
`default_nettype none
`include "l2cds_regs.svh"
module l2cds_top
  import l2cds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic addrStrobe_n,
  input wire logic [31:0] addr,
  input wire logic writeCycle,
  input wire logic [31:0] wdata,
  input wire logic last_transfer_n,
  output logic [31:0] rdata,
  output logic cycle_done_n,
  output logic burst_done_n,
  output l2cds_dram_t dram,
  input wire logic [31:0] dramRdata
);
  // ************************************************************
  // Storage
  // ************************************************************
  // One unit of 128 KB, used alone: 4096 sets x 2 ways
  // x four doublewords x 4 bytes
  localparam int Sets = `L2_SETS; // R01 R02
  logic [31:0] dataMem [`L2_WAYS][Sets][`L2_LINE_DW]; // R03
  logic [`L2_TAG_W-1:0] tagMem [`L2_WAYS][Sets];
  logic validMem [`L2_WAYS][Sets];
  logic lruMem [Sets];

  typedef enum logic [2:0] {
    C_IDLE, C_LOOK, C_HIT, C_MISS, C_WRITE
  } l2cds_cst_t;
  typedef struct packed {
    l2cds_cst_t st;
    logic [31:0] addr;
    logic write;
    logic burst;
    logic [1:0] beat;
    logic way;
    logic [31:0] rdata;
    logic cdN;
    logic bdN;
    logic [`WB_PTR_W:0] wbCnt;
    logic [`WB_PTR_W-1:0] wbHead;
    logic [`WB_PTR_W-1:0] wbTail;
    logic dramBusy;
  } l2cds_cstate_t;
  l2cds_cstate_t s, next_s;
  logic [63:0] wbMem [`WB_DEPTH];

  // ************************************************************
  // Lookup
  // ************************************************************
  function automatic logic [`L2_IDX_W-1:0] idxOf(input logic [31:0] a);
    return a[`L2_IDX_HI:`L2_IDX_LO];
  endfunction
  function automatic logic [`L2_TAG_W-1:0] tagOf(input logic [31:0] a);
    return a[31:`L2_TAG_LO];
  endfunction

  logic [`L2_IDX_W-1:0] idx;
  logic [1:0] hitVec;
  logic hit;
  logic hitWay;
  logic [1:0] beatOfs;
  assign idx = idxOf(s.addr);
  assign beatOfs = s.addr[`L2_OFS_HI:`L2_OFS_LO] + s.beat;
  genvar gw;
  generate
    for (gw = 0; gw < `L2_WAYS; gw++) begin : g_cmp
      assign hitVec[gw] = validMem[gw][idx] &&
                          tagMem[gw][idx] == tagOf(s.addr); // R04
    end
  endgenerate
  assign hit = |hitVec;
  assign hitWay = hitVec[1];

  // ************************************************************
  // DRAM port: fills have priority only when buffer empty
  // ************************************************************
  logic dValid;
  logic dDone;
  logic [31:0] dRdata;
  l2cds_req_t dReq;
  logic fillSel;
  logic wbFull;
  assign wbFull = (s.wbCnt == (`WB_PTR_W+1)'(`WB_DEPTH));
  // Fills wait for buffer drain so reads never overtake writes
  assign fillSel = (s.st == C_MISS) && (s.wbCnt == '0);
  always_comb begin
    dReq.fill = fillSel;
    dReq.write = !fillSel;
    if (fillSel) begin
      dReq.addr = {s.addr[31:`L2_IDX_LO], beatOfs, 2'h0};
      dReq.data = '0;
    end else begin
      dReq.addr = wbMem[s.wbHead][63:32];
      dReq.data = wbMem[s.wbHead][31:0];
    end
  end
  assign dValid = fillSel || (s.wbCnt != '0); // R21

  l2cds_dram u_dram (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reqValid(dValid),
    .req(dReq),
    .reqDone(dDone),
    .rdata(dRdata),
    .dram(dram),
    .dramRdata(dramRdata)
  );

  // ************************************************************
  // Processor cycle control
  // ************************************************************
  logic pushWb;
  logic popWb;
  logic fillWr;
  logic hitWr;
  assign popWb = dDone && !s.dramBusy && (s.wbCnt != '0);
  always_comb begin
    next_s = s;
    next_s.cdN = 1'b1;
    next_s.bdN = 1'b1;
    next_s.dramBusy = fillSel;
    pushWb = 1'b0;
    fillWr = 1'b0;
    hitWr = 1'b0;
    case (s.st)
      C_IDLE: begin
        if (!addrStrobe_n) begin
          next_s.addr = addr;
          next_s.write = writeCycle;
          next_s.beat = '0;
          next_s.st = writeCycle ? C_WRITE : C_LOOK;
        end
      end
      C_LOOK: begin
        next_s.burst = last_transfer_n; // R19
        if (hit) begin
          next_s.way = hitWay;
          next_s.rdata = dataMem[hitWay][idx][beatOfs]; // R05
          next_s.bdN = 1'b0; // R04 R19
          next_s.st = C_HIT;
        end else begin
          // Empty way first, so the unreset age bits are never read
          next_s.way = !validMem[0][idx] ? 1'b0 :
                       !validMem[1][idx] ? 1'b1 : lruMem[idx];
          next_s.st = C_MISS; // R06
        end
      end
      C_HIT: begin
        if (s.beat == 2'h3 || !s.burst) begin
          next_s.st = C_IDLE;
        end else begin
          next_s.beat = s.beat + 2'h1;
          next_s.rdata = dataMem[s.way][idx][2'(beatOfs + 2'h1)];
          next_s.bdN = 1'b0; // R05 R13
        end
      end
      C_MISS: begin
        if (dDone && s.dramBusy) begin
          fillWr = 1'b1; // R06
          next_s.rdata = dRdata;
          next_s.bdN = 1'b0; // R19
          next_s.beat = s.beat + 2'h1;
          if (s.beat == 2'h3) begin
            next_s.st = C_IDLE;
          end
          next_s.dramBusy = 1'b0;
        end
      end
      C_WRITE: begin
        // Acknowledge at once; full buffer holds cycle-done high until a write drains
        if (!wbFull || popWb) begin
          pushWb = 1'b1; // R08 R17
          hitWr = hit; // R07
          next_s.cdN = 1'b0; // R18
          next_s.st = C_IDLE;
        end
      end
      default: next_s.st = C_IDLE;
    endcase
    if (pushWb) begin
      next_s.wbTail = s.wbTail + 1'b1;
    end
    if (popWb) begin
      next_s.wbHead = s.wbHead + 1'b1; // R21
    end
    next_s.wbCnt = s.wbCnt + (`WB_PTR_W+1)'(pushWb) -
                   (`WB_PTR_W+1)'(popWb); // R21
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= C_IDLE;
      s.cdN <= 1'b1;
      s.bdN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Arrays carry no reset; valid bits are cleared below
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int w = 0; w < `L2_WAYS; w++) begin
        for (int i = 0; i < Sets; i++) begin
          validMem[w][i] <= 1'b0;
        end
      end
    end else if (fillWr) begin
      validMem[s.way][idx] <= (s.beat == 2'h3); // R06
    end
  end
  always_ff @(posedge clk_sys) begin
    if (pushWb) begin
      wbMem[s.wbTail] <= {s.addr, wdata}; // R17
    end
    if (hitWr) begin
      dataMem[hitWay][idx][s.addr[`L2_OFS_HI:`L2_OFS_LO]] <= wdata; // R07
    end
    if (fillWr) begin
      dataMem[s.way][idx][beatOfs] <= dRdata;
      tagMem[s.way][idx] <= tagOf(s.addr);
      lruMem[idx] <= !s.way;
    end
    if (s.st == C_LOOK && hit) begin
      lruMem[idx] <= !hitWay;
    end
  end

  assign rdata = s.rdata;
  assign cycle_done_n = s.cdN;
  assign burst_done_n = s.bdN;
endmodule // l2cds_top
`default_nettype wire

// ---- testbench/l2cds_sva.sv ----
/* Port checker for the cache subsystem.
   Assumes it is bound to l2cds_top, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module l2cds_sva
  import l2cds_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic addrStrobe_n,
  input wire logic [31:0] rdata,
  input wire logic cycle_done_n,
  input wire logic burst_done_n,
  input wire l2cds_dram_t dram
);
  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_no_early_done: assert property (!addrStrobe_n |=>
    burst_done_n && cycle_done_n) else $error("done one clock after start");
  a_done_pulse: assert property ($fell(cycle_done_n) |=> cycle_done_n)
    else $error("cycle done wider than one clock");
  a_done_apart: assert property (cycle_done_n || burst_done_n)
    else $error("both done strobes low");
  a_ras_shared: assert property (dram.rasN == 4'h0 || dram.rasN == 4'hf)
    else $error("row strobes split");
  a_row_first: assert property ($fell(dram.rasN[0]) |->
    dram.casN == 4'hf) else $error("column strobe before row strobe");
  a_page_row: assert property (!dram.rasN[0] && !$past(dram.rasN[0]) |->
    $stable(dram.row)) else $error("row changed in open page");
  a_rdata_hold: assert property (burst_done_n |-> $stable(rdata))
    else $error("read data moved between beats");
  a_write_thru: assert property ($fell(cycle_done_n) |->
    ##[0:300] !dram.weN) else $error("posted write never reached memory");
  c_write: cover property ($fell(cycle_done_n));
  c_beat: cover property ($fell(burst_done_n));
  c_open: cover property ($fell(dram.rasN[0]));
endmodule // l2cds_sva
`default_nettype wire

// ---- testbench/l2cds_cpu.sv ----
/* Processor side model issuing burst reads and single writes.
   Assumes one cycle at a time; bench calls op hierarchically. */
`timescale 1ns/1ps
`default_nettype none
module l2cds_cpu (
  input wire logic clk_sys,
  input wire logic cycle_done_n,
  input wire logic burst_done_n,
  output logic addrStrobe_n,
  output logic [31:0] addr,
  output logic writeCycle,
  output logic [31:0] wdata,
  output logic last_transfer_n
);
  // ****************
  // Bus cycles
  // ****************
  initial begin
    addrStrobe_n = 1'b1;
    addr = 32'h0;
    writeCycle = 1'b0;
    wdata = 32'h0;
    last_transfer_n = 1'b1;
  end
  // Address and data stay put until the next cycle starts
  task automatic op(input logic w, input logic [31:0] a,
    input logic [31:0] d, output int lat, output int fin);
    int beats;
    beats = 0;
    lat = 0;
    fin = 0;
    @(posedge clk_sys);
    addrStrobe_n <= 1'b0;
    addr <= a;
    writeCycle <= w;
    wdata <= d;
    last_transfer_n <= !w;
    @(posedge clk_sys);
    addrStrobe_n <= 1'b1;
    for (int i = 1; i < 600 && beats < (w ? 1 : 4); i++) begin
      @(posedge clk_sys);
      #1;
      if (w ? cycle_done_n === 1'b0 : burst_done_n === 1'b0) begin
        // Done seen after edge i is sampled by the processor at edge i+1
        if (beats == 0) lat = i + 1;
        fin = i + 1;
        beats++;
      end
    end
  endtask
endmodule // l2cds_cpu
`default_nettype wire

// ---- testbench/l2cds_top_bench.sv ----
/* Self-checking bench: processor model, DRAM model, scoreboard.
   Assumes DRAM data appears in the clock its column strobe is low. */
`timescale 1ns/1ps
`default_nettype none
module l2cds_top_bench
  import l2cds_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic addrStrobe_n, writeCycle, last_transfer_n;
  logic cycle_done_n, burst_done_n, cpuDone;
  logic [31:0] addr, wdata, rdata, dramRdata, a;
  logic [31:0] junk = 32'h0;
  logic [1:0] bank;
  l2cds_dram_t dram;
  logic [31:0] mem [int];
  logic [31:0] shadow [int];
  logic [31:0] expq [$];
  int failures = 0, n_tests = 0, cycles = 0, seed = 67, lat, fin, key;
  // ****************
  // Models and scoreboard
  // ****************
  initial forever #2.5 clk_sys = ~clk_sys;
  l2cds_top l2cds_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .addrStrobe_n(addrStrobe_n), .addr(addr), .writeCycle(writeCycle),
    .wdata(wdata), .last_transfer_n(last_transfer_n), .rdata(rdata),
    .cycle_done_n(cycle_done_n), .burst_done_n(burst_done_n),
    .dram(dram), .dramRdata(dramRdata));
  l2cds_cpu l2cds_cpu_inst (.clk_sys(clk_sys), .cycle_done_n(cycle_done_n),
    .burst_done_n(burst_done_n), .addrStrobe_n(addrStrobe_n), .addr(addr),
    .writeCycle(writeCycle), .wdata(wdata),
    .last_transfer_n(last_transfer_n));
  always_comb begin
    bank = 2'h0;
    for (int b = 3; b >= 0; b--) if (!dram.casN[b]) bank = 2'(b);
    key = {10'h0, dram.row, dram.col, bank};
    // Deselected bus alternates between 00000000 and fffffffe every clock
    if (dram.casN == 4'hf) dramRdata = junk;
    else if (mem.exists(key)) dramRdata = mem[key];
    else dramRdata = {dram.row, dram.col, bank, 10'h0};
  end
  always @(posedge clk_sys) begin
    junk <= ~junk ^ 32'h1;
    if (!dram.weN && dram.casN != 4'hf) mem[key] = dram.wdata;
  end
  function automatic logic [31:0] expv(logic [31:0] x);
    return shadow.exists(x[23:2]) ? shadow[x[23:2]] : {x[23:2], 10'h0};
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic close_out();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd(logic [31:0] x);
    for (int i = 0; i < 4; i++)
      expq.push_back(expv({x[31:4], 2'(x[3:2] + i), 2'h0}));
    l2cds_cpu_inst.op(1'b0, x, 32'h0, lat, fin);
  endtask
  task automatic wr(logic [31:0] x, logic [31:0] v);
    shadow[x[23:2]] = v;
    l2cds_cpu_inst.op(1'b1, x, v, lat, fin);
  endtask
  always @(posedge clk_sys) begin
    #1;
    if (burst_done_n === 1'b0) begin
      if (expq.size() == 0) chk("extra_beat", 32'h1, 32'h0);
      else chk("rdata", rdata, expq.pop_front());
    end
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(32'h00123454);
    chk("miss_lat", 32'(lat > 2), 32'h1);
    rd(32'h00123458);
    chk("hit_lat", 32'(lat), 32'h2);
    chk("hit_end", 32'(fin), 32'h5);
    wr(32'h00123450, 32'h5a5a0001);
    chk("wr_lat", 32'(lat), 32'h2);
    rd(32'h00123450);
    chk("wr_hit", 32'(lat), 32'h2);
    wr(32'h00456780, 32'h0f0f0002);
    rd(32'h00456780);
    chk("no_alloc", 32'(lat > 2), 32'h1);
    // Same place written twice: only the later value may survive
    for (int i = 0; i < 6; i++) wr(32'h00200010 + 32'(i % 3 * 4), $random(seed));
    rd(32'h00200010);
    repeat (24) begin
      a = $random(seed) & 32'h0030c03c;
      if (a[2]) wr(a, $random(seed));
      else rd(a);
    end
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(32'h00123454);
    chk("reset_miss", 32'(lat > 2), 32'h1);
    repeat (4) @(posedge clk_sys);
    chk("left", 32'(expq.size()), 32'h0);
    close_out();
  end
endmodule // l2cds_top_bench
bind l2cds_top l2cds_sva l2cds_sva_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .addrStrobe_n(addrStrobe_n), .rdata(rdata), .cycle_done_n(cycle_done_n),
  .burst_done_n(burst_done_n), .dram(dram));
`default_nettype wire
